// [pkg/tmd_pkg.sv]
// Constants and carrier types for the transceiver data query block.
// Assumes one clock domain; all users refer to names as tmd_pkg::name.
package tmd_pkg;

    // Command and response packet types
    localparam logic [7:0] TMD_CMD_TYPE = 8'h32;
    localparam logic [7:0] TMD_RSP_TYPE = 8'hb2;

    // Command byte positions, counted from the packet start
    localparam logic [5:0] TMD_TYPE_IDX = 6'h04;
    localparam logic [5:0] TMD_BANK_IDX = 6'h10;
    localparam logic [5:0] TMD_PAGE_IDX = 6'h11;
    localparam logic [5:0] TMD_FLAGS_IDX = 6'h13;
    localparam logic [5:0] TMD_CIDX_MAX = 6'h3f;
    localparam int TMD_FLAG_UPPER_BIT = 0;

    // Response payload positions, byte 0 is packet byte 16
    localparam logic [7:0] TMD_RSP_RC_HI = 8'h00;
    localparam logic [7:0] TMD_RSP_RC_LO = 8'h01;
    localparam logic [7:0] TMD_RSP_RS_HI = 8'h02;
    localparam logic [7:0] TMD_RSP_RS_LO = 8'h03;
    localparam logic [7:0] TMD_RSP_MAXBANK = 8'h04;
    localparam logic [7:0] TMD_RSP_MAXPAGE = 8'h05;
    localparam logic [7:0] TMD_RSP_BANK = 8'h06;
    localparam logic [7:0] TMD_RSP_PAGE = 8'h07;
    localparam logic [7:0] TMD_RSP_DATA0 = 8'h08;
    localparam logic [7:0] TMD_RSP_LAST_OK = 8'h87;
    localparam logic [7:0] TMD_RSP_LAST_ERR = 8'h03;
    localparam logic [6:0] TMD_BLK_LAST = 7'h7f;
    localparam logic [7:0] TMD_PAGE_UNKNOWN = 8'hff;

    // Response and reason codes
    localparam logic [15:0] TMD_RC_OK = 16'h0000;
    localparam logic [15:0] TMD_RC_FAILED = 16'h0001;
    localparam logic [15:0] TMD_RC_UNAVAIL = 16'h0002;
    localparam logic [15:0] TMD_RC_UNSUP = 16'h0003;
    localparam logic [15:0] TMD_RC_DELAYED = 16'h0004;
    localparam logic [15:0] TMD_RS_NONE = 16'h0000;
    localparam logic [15:0] TMD_RS_RANGE = 16'h0002;
    localparam logic [15:0] TMD_RS_UNSUP = 16'h0003;
    localparam logic [15:0] TMD_RS_NOINFO = 16'h0009;
    localparam logic [15:0] TMD_RS_NOPOWER = 16'h000a;
    localparam logic [15:0] TMD_RS_TIMEOUT = 16'h000b;

    // Register byte offsets and fields
    localparam logic [7:0] TMD_REG_CTRL = 8'h00;
    localparam logic [7:0] TMD_REG_LIMIT = 8'h04;
    localparam logic [7:0] TMD_REG_TIMEOUT = 8'h08;
    localparam logic [7:0] TMD_REG_STATUS = 8'h0c;
    localparam logic [7:0] TMD_REG_COUNT = 8'h10;
    localparam int TMD_CTRL_PLUG_BIT = 0;
    localparam int TMD_CTRL_CACHE_BIT = 1;
    localparam int TMD_CTRL_LEGACY_BIT = 2;
    localparam int TMD_CTRL_DELAY_BIT = 3;
    localparam int TMD_LIMIT_BANK_LSB = 0;
    localparam int TMD_LIMIT_PAGE_LSB = 8;
    localparam logic [31:0] TMD_CTRL_RST = 32'h00000003;
    localparam logic [31:0] TMD_LIMIT_RST = 32'h0000ff00;
    localparam logic [15:0] TMD_TIMEOUT_RST = 16'h03e8;

    typedef enum logic [1:0] {
        TMD_IDLE = 2'b00,
        TMD_CHECK = 2'b01,
        TMD_FETCH = 2'b10,
        TMD_SEND = 2'b11
    } tmd_state_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } tmd_cmd_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] kind;
        logic [7:0] data;
    } tmd_rsp_t;

    typedef struct packed {
        logic req;
        logic [7:0] bank;
        logic [7:0] page;
        logic [7:0] addr;
    } tmd_mi_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] rdata;
    } tmd_mi_rsp_t;

    typedef struct packed {
        logic present;
        logic powered;
        logic busy;
    } tmd_mod_t;

    typedef struct packed {
        logic pluggable;
        logic cache_en;
        logic legacy;
        logic delayed;
        logic [7:0] max_bank;
        logic [7:0] max_page;
        logic [15:0] timeout;
    } tmd_cfg_t;

endpackage

// [sim/testbench.sv]
// Self-checking bench for the transceiver data query block.
// Drives AHB, command bytes and module status; model answers reads.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic rsp_ready = 1'b1;
    logic rstn, hsel, hwrite, hreadyout, hresp, cmd_ready, fail, fin;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [31:0] lf = 32'h143c;
    logic [7:0] lat, mb, mp;
    tmd_pkg::tmd_cmd_t cmd;
    tmd_pkg::tmd_rsp_t rsp;
    tmd_pkg::tmd_mod_t mod_stat;
    tmd_pkg::tmd_mi_req_t mi;
    tmd_pkg::tmd_mi_rsp_t mi_rsp;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    logic [7:0] got[$];
    logic [7:0] exp[$];
    always #2 clk_sys = ~clk_sys;
    tmd_xcvr_query uut (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cmd,
        .cmd_ready, .rsp, .rsp_ready, .mod_stat, .mi, .mi_rsp);
    tmd_mi_model far (.clk_sys, .rstn, .mi, .lat, .fail, .mi_rsp);
    function automatic logic [7:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (!hreadyout);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (!hreadyout);
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask
    // Stalls every fourth cycle so held response bytes are exercised
    always @(posedge clk_sys) begin
        cyc++;
        rsp_ready <= (cyc % 4) != 0;
        if (rsp.valid && rsp_ready) begin
            got.push_back(rsp.data);
            fin = rsp.last;
        end
    end
    task automatic query(input logic [7:0] b, input logic [7:0] p,
            input logic [7:0] f, input logic [15:0] rc,
            input logic [15:0] rs, input logic [7:0] db, input logic h);
        int n;
        exp = '{rc[15:8], rc[7:0], rs[15:8], rs[7:0]};
        if (rc == 16'h0000) begin
            exp = {exp, mb, mp, b, p};
            for (int i = 0; i < 128; i++)
                exp.push_back({h, i[6:0]} ^ p ^ {db[3:0], 4'h5});
        end
        got.delete();
        fin = 1'b0;
        for (int i = 0; i < 24; i++) begin
            cmd <= '{1'b1, i == 23, i == 4 ? 8'h32 : i == 16 ? b :
                i == 17 ? p : i == 19 ? f : rnd()};
            do @(posedge clk_sys); while (!cmd_ready);
        end
        cmd <= '0;
        n = 0;
        while (!fin && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(got.size(), exp.size());
        foreach (exp[i]) chk(got[i], exp[i]);
        $display("Test done: bank %h page %h flags %h", b, p, f);
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end
    initial begin
        rstn = 1'b0;
        {hsel, htrans, hwrite} = '0;
        {haddr, hwdata} = '0;
        cmd = '0;
        mod_stat = 3'b110;
        lat = 8'h02;
        fail = 1'b0;
        mb = 8'h01;
        mp = 8'h03;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        ahb(1'b0, 8'h00, '0);
        chk(rd, 32'h3);
        ahb(1'b0, 8'h04, '0);
        chk(rd, 32'hff00);
        ahb(1'b1, 8'h40, 32'h5);
        ahb(1'b0, 8'h40, '0);
        chk(rd, 32'h0);
        ahb(1'b1, 8'h04, 32'h0301);
        ahb(1'b1, 8'h08, 32'h14);
        query(8'h01, 8'h02, 8'h00, 0, 0, 8'h01, 1'b0);
        query(8'h01, rnd() & 8'h03, rnd() | 8'h01, 0, 0, 8'h01, 1'b1);
        query(8'h02, 8'h00, 8'h00, 16'h1, 16'h2, 8'h00, 1'b0);
        query(8'h00, 8'h04, 8'h00, 16'h1, 16'h2, 8'h00, 1'b0);
        query(8'h00, 8'h00, 8'h01, 0, 0, 8'h00, 1'b1);
        fail <= 1'b1;
        query(8'h00, 8'h00, 8'h01, 0, 0, 8'h00, 1'b1);
        query(8'h00, 8'h01, 8'h00, 16'h1, 16'h9, 8'h00, 1'b0);
        fail <= 1'b0;
        lat <= 8'h28;
        query(8'h00, 8'h01, 8'h00, 16'h1, 16'hb, 8'h00, 1'b0);
        ahb(1'b1, 8'h00, 32'hb);
        query(8'h00, 8'h01, 8'h00, 16'h4, 16'h0, 8'h00, 1'b0);
        lat <= 8'h02;
        ahb(1'b1, 8'h00, 32'h5);
        query(8'h01, 8'h00, 8'h00, 0, 0, 8'h00, 1'b1);
        ahb(1'b1, 8'h04, 32'hff00);
        ahb(1'b1, 8'h00, 32'h1);
        mb = 8'h00;
        mp = 8'hff;
        query(8'h00, 8'h09, 8'h00, 0, 0, 8'h00, 1'b0);
        mod_stat <= 3'b010;
        query(8'h00, 8'h01, 8'h00, 16'h2, 16'h9, 8'h00, 1'b0);
        mod_stat <= 3'b111;
        query(8'h00, 8'h01, 8'h00, 16'h1, 16'h9, 8'h00, 1'b0);
        mod_stat <= 3'b100;
        query(8'h00, 8'h01, 8'h00, 16'h1, 16'ha, 8'h00, 1'b0);
        mod_stat <= 3'b110;
        ahb(1'b1, 8'h00, 32'h0);
        query(8'h00, 8'h01, 8'h00, 16'h3, 16'h3, 8'h00, 1'b0);
        ahb(1'b0, 8'h10, '0);
        chk(rd, 32'h00090006);
        report_and_stop();
    end
endmodule
bind tmd_xcvr_query tmd_xcvr_query_assertions chk_i (.clk_sys, .rstn,
    .cmd, .cmd_ready, .rsp, .rsp_ready, .mod_stat, .mi, .mi_rsp);
`default_nettype wire

// [sim/tmd_mi_model.sv]
// Module management side: answers each byte read after a set latency.
// Driven by the bench; data is a fixed mix of bank, page and address.
`timescale 1ns/1ps
`default_nettype none
module tmd_mi_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire tmd_pkg::tmd_mi_req_t mi,
    input wire logic [7:0] lat,
    input wire logic fail,
    output var tmd_pkg::tmd_mi_rsp_t mi_rsp
);
    logic [7:0] cnt;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt <= 8'h00;
            mi_rsp <= '0;
        end else begin
            // Released data flips so a stale byte never matches
            mi_rsp <= '{1'b0, 1'b0, ~mi_rsp.rdata};
            cnt <= 8'h00;
            if (mi.req && !mi_rsp.ack) begin
                cnt <= cnt + 8'h01;
                if (cnt == lat) begin
                    mi_rsp <= '{1'b1, fail,
                        mi.addr ^ mi.page ^ {mi.bank[3:0], 4'h5}};
                end
            end
        end
    end
endmodule
`default_nettype wire

// [sim/tmd_xcvr_query_assertions.sv]
// Checker for the query block's command, response and module ports.
// Bound to the top from the bench; sees only top-level ports.
`timescale 1ns/1ps
`default_nettype none
module tmd_xcvr_query_assertions (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire tmd_pkg::tmd_cmd_t cmd,
    input wire logic cmd_ready,
    input wire tmd_pkg::tmd_rsp_t rsp,
    input wire logic rsp_ready,
    input wire tmd_pkg::tmd_mod_t mod_stat,
    input wire tmd_pkg::tmd_mi_req_t mi,
    input wire tmd_pkg::tmd_mi_rsp_t mi_rsp
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic end_cmd;
    assign end_cmd = cmd.valid && cmd.last && cmd_ready;
    a_rsp_kind: assert property (rsp.valid |-> rsp.kind == 8'hb2)
        else $error("response kind wrong");
    a_rsp_hold: assert property (rsp.valid && !rsp_ready |=>
        rsp.valid && $stable(rsp.data) && $stable(rsp.last))
        else $error("response byte not held");
    a_mi_hold: assert property (mi.req && !mi_rsp.ack |=>
        $stable(mi) || $fell(mi.req))
        else $error("module request changed early");
    a_absent_nofetch: assert property (end_cmd && !mod_stat.present
        |-> ##1 (!mi.req) [*3])
        else $error("fetch with no module");
    a_busy_nofetch: assert property (end_cmd && mod_stat.busy
        |-> ##1 (!mi.req) [*3])
        else $error("fetch while module busy");
    a_off_nofetch: assert property (end_cmd && !mod_stat.powered
        |-> ##1 (!mi.req) [*3])
        else $error("fetch while module unpowered");
    a_fetch_first: assert property (mi.req |-> !rsp.valid)
        else $error("response during fetch");
    a_cmd_block: assert property (end_cmd |=> !cmd_ready)
        else $error("command taken during query");
    c_done: cover property (rsp.valid && rsp.last && rsp_ready);
    c_err: cover property (mi.req && mi_rsp.ack && mi_rsp.err);
    c_tout: cover property ($fell(mi.req) && !$past(mi_rsp.ack));
endmodule
`default_nettype wire

// [src/tmd_ahb_regs.sv]
// AHB-Lite register slave for the transceiver data query block.
// Assumes a single master, word transfers, zero wait states.
`timescale 1ns/1ps
`default_nettype none
module tmd_ahb_regs (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output tmd_pkg::tmd_cfg_t cfg,
    input wire logic [31:0] status_word,
    input wire logic [31:0] count_word
);
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        tmd_pkg::tmd_cfg_t cfg;
    } tmd_regs_t;

    tmd_regs_t s;
    tmd_regs_t n;

    always_comb begin
        n = s;
        n.ready = 1'b1;
        // Write lands in the data phase, when hwdata is valid
        if (s.wr_pend) begin
            case (s.wr_addr)
                tmd_pkg::TMD_REG_CTRL: begin
                    n.cfg.pluggable = hwdata[tmd_pkg::TMD_CTRL_PLUG_BIT];
                    n.cfg.cache_en = hwdata[tmd_pkg::TMD_CTRL_CACHE_BIT];
                    n.cfg.legacy = hwdata[tmd_pkg::TMD_CTRL_LEGACY_BIT];
                    n.cfg.delayed = hwdata[tmd_pkg::TMD_CTRL_DELAY_BIT];
                end
                tmd_pkg::TMD_REG_LIMIT: begin
                    n.cfg.max_bank = hwdata[tmd_pkg::TMD_LIMIT_BANK_LSB +: 8];
                    n.cfg.max_page = hwdata[tmd_pkg::TMD_LIMIT_PAGE_LSB +: 8];
                end
                tmd_pkg::TMD_REG_TIMEOUT: n.cfg.timeout = hwdata[15:0];
                default: ;
            endcase
        end
        n.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            n.wr_pend = hwrite && (haddr[31:5] == 27'h0);
            n.wr_addr = {haddr[7:2], 2'b00};
            n.rdata = 32'h0;
            // Read from n so a write just before is already seen
            if (!hwrite && haddr[31:5] == 27'h0) begin
                case ({haddr[7:2], 2'b00})
                    tmd_pkg::TMD_REG_CTRL: n.rdata = {28'h0, n.cfg.delayed,
                        n.cfg.legacy, n.cfg.cache_en, n.cfg.pluggable};
                    tmd_pkg::TMD_REG_LIMIT: n.rdata = {16'h0,
                        n.cfg.max_page, n.cfg.max_bank};
                    tmd_pkg::TMD_REG_TIMEOUT: n.rdata = {16'h0, n.cfg.timeout};
                    tmd_pkg::TMD_REG_STATUS: n.rdata = status_word;
                    tmd_pkg::TMD_REG_COUNT: n.rdata = count_word;
                    default: n.rdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.ready <= 1'b1;
            s.cfg.pluggable <= tmd_pkg::TMD_CTRL_RST[tmd_pkg::TMD_CTRL_PLUG_BIT];
            s.cfg.cache_en <= tmd_pkg::TMD_CTRL_RST[tmd_pkg::TMD_CTRL_CACHE_BIT];
            s.cfg.max_page <= tmd_pkg::TMD_LIMIT_RST[15:8];
            s.cfg.timeout <= tmd_pkg::TMD_TIMEOUT_RST;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = s.ready;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign cfg = s.cfg;
endmodule
`default_nettype wire

// [src/tmd_mi_engine.sv]
// One-byte read handshake toward the module management interface.
// Assumes the far side pulses ack for one cycle while req is high.
`timescale 1ns/1ps
`default_nettype none
module tmd_mi_engine (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic start,
    input wire logic [7:0] bank,
    input wire logic [7:0] page,
    input wire logic [7:0] addr,
    input wire logic [15:0] timeout,
    input wire tmd_pkg::tmd_mi_rsp_t mi_rsp,
    output tmd_pkg::tmd_mi_req_t mi,
    output logic done,
    output logic err,
    output logic tout,
    output logic [7:0] rdata
);
    typedef struct packed {
        tmd_pkg::tmd_mi_req_t mi;
        logic [15:0] cnt;
        logic done;
        logic err;
        logic tout;
        logic [7:0] rdata;
    } tmd_eng_t;

    tmd_eng_t s;
    tmd_eng_t n;

    always_comb begin
        n = s;
        n.done = 1'b0;
        if (!s.mi.req) begin
            if (start) begin
                n.mi = '{req: 1'b1, bank: bank, page: page, addr: addr};
                n.cnt = 16'h0;
                n.err = 1'b0;
                n.tout = 1'b0;
            end
        end else if (mi_rsp.ack) begin
            n.mi.req = 1'b0;
            n.done = 1'b1;
            n.err = mi_rsp.err;
            n.rdata = mi_rsp.rdata;
        end else if (s.cnt >= timeout) begin
            // Late acks after this are ignored since req is low
            n.mi.req = 1'b0;
            n.done = 1'b1;
            n.tout = 1'b1;
        end else begin
            n.cnt = s.cnt + 16'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign mi = s.mi;
    assign done = s.done;
    assign err = s.err;
    assign tout = s.tout;
    assign rdata = s.rdata;
endmodule
`default_nettype wire

// [src/tmd_xcvr_query.sv]
// Transceiver management data query handler, top level.
// Assumes command bytes arrive in packet order from byte 0, one per
// accepted beat, and that header checksum checks are done upstream.
// Operation
// RULE1: Accept type 0x32, return 128-byte block
// RULE2: Fetch exactly the requested bank and page
// RULE3: Legacy modules: lower page bank 0, upper 1
// RULE4: Single-bank module answers with bank zero
// RULE5: Upper page zero may be served cached
// RULE6: All mandatory pages must be readable
// RULE7: No pluggable module: reply unsupported
// RULE8: Bank byte 16, page 17, flags 19
// RULE9: Flags bit 0 picks upper or lower half
// RULE10: No module: unavailable, information not available
// RULE11: Bad bank or page: failed, out of range
// RULE12: Module resetting: failed, information not available
// RULE13: Module powered down: failed, not powered
// RULE14: Module too slow: timeout or delayed response
// RULE15: Success layout: codes, limits, echo, data
// RULE16: Max bank is highest bank, else zero
// RULE17: Max page highest, 0xff when unknown
// RULE18: Echo requested bank and page numbers
// RULE19: Fetch all bytes first, abort on error
`timescale 1ns/1ps
`default_nettype none
module tmd_xcvr_query (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire tmd_pkg::tmd_cmd_t cmd,
    output logic cmd_ready,
    output tmd_pkg::tmd_rsp_t rsp,
    input wire logic rsp_ready,
    input wire tmd_pkg::tmd_mod_t mod_stat,
    output tmd_pkg::tmd_mi_req_t mi,
    input wire tmd_pkg::tmd_mi_rsp_t mi_rsp
);
    typedef struct packed {
        tmd_pkg::tmd_state_t st;
        logic [5:0] cidx;
        logic [7:0] ctype;
        logic [7:0] cbank;
        logic [7:0] cpage;
        logic [7:0] cflags;
        logic cmd_ready;
        logic [7:0] idx;
        logic start;
        logic ok;
        logic fill;
        logic [15:0] rcode;
        logic [15:0] rreas;
        logic [127:0][7:0] dbuf;
        logic [127:0][7:0] cache;
        logic cache_valid;
        tmd_pkg::tmd_rsp_t rsp;
        logic [15:0] served;
        logic [15:0] failed;
    } tmd_main_t;

    tmd_main_t s;
    tmd_main_t n;
    tmd_pkg::tmd_cfg_t cfg;
    logic eng_done;
    logic eng_err;
    logic eng_tout;
    logic [7:0] eng_data;
    logic [7:0] mi_bank;
    logic [7:0] mi_addr;
    logic half;
    logic range_bad;
    logic page0_upper;

    // Payload byte i of the response, byte 0 being packet byte 16
    function automatic logic [7:0] tmd_rsp_byte(
        input tmd_main_t x,
        input logic [7:0] i,
        input tmd_pkg::tmd_cfg_t c
    );
        logic [7:0] j;
        j = i - tmd_pkg::TMD_RSP_DATA0;
        case (i)
            tmd_pkg::TMD_RSP_RC_HI: tmd_rsp_byte = x.rcode[15:8]; // RULE15
            tmd_pkg::TMD_RSP_RC_LO: tmd_rsp_byte = x.rcode[7:0];
            tmd_pkg::TMD_RSP_RS_HI: tmd_rsp_byte = x.rreas[15:8];
            tmd_pkg::TMD_RSP_RS_LO: tmd_rsp_byte = x.rreas[7:0];
            tmd_pkg::TMD_RSP_MAXBANK: tmd_rsp_byte = c.max_bank; // RULE16
            tmd_pkg::TMD_RSP_MAXPAGE: tmd_rsp_byte = c.max_page; // RULE17
            tmd_pkg::TMD_RSP_BANK: tmd_rsp_byte = x.cbank; // RULE18
            tmd_pkg::TMD_RSP_PAGE: tmd_rsp_byte = x.cpage; // RULE18
            default: tmd_rsp_byte = x.dbuf[j[6:0]]; // RULE15
        endcase
    endfunction

    tmd_ahb_regs u_regs (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .cfg(cfg),
        .status_word({s.rreas[7:0], s.rcode[7:0], 8'h0, 2'b00,
            mod_stat.busy, mod_stat.powered, mod_stat.present,
            s.cache_valid, s.st}),
        .count_word({s.failed, s.served})
    );

    // Legacy modules carry the half in the bank number
    assign half = s.cflags[tmd_pkg::TMD_FLAG_UPPER_BIT]
        | (cfg.legacy & s.cbank[0]); // RULE3 RULE9
    assign mi_bank = cfg.legacy ? 8'h00 : s.cbank; // RULE3 RULE2
    assign mi_addr = {half, s.idx[6:0]}; // RULE2 RULE9
    // Page limit check is skipped when the limit is unknown
    assign range_bad = (s.cbank > cfg.max_bank)
        || (cfg.max_page != tmd_pkg::TMD_PAGE_UNKNOWN
        && s.cpage > cfg.max_page); // RULE11 RULE4
    assign page0_upper = half && s.cpage == 8'h00
        && (cfg.legacy || s.cbank == 8'h00);

    tmd_mi_engine u_eng (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(s.start),
        .bank(mi_bank),
        .page(s.cpage),
        .addr(mi_addr),
        .timeout(cfg.timeout),
        .mi_rsp(mi_rsp),
        .mi(mi),
        .done(eng_done),
        .err(eng_err),
        .tout(eng_tout),
        .rdata(eng_data)
    );

    always_comb begin
        n = s;
        n.start = 1'b0;
        // A changed or missing module makes the cached copy stale
        if (!mod_stat.present || !mod_stat.powered || mod_stat.busy) begin
            n.cache_valid = 1'b0; // RULE5
        end
        case (s.st)
            tmd_pkg::TMD_IDLE: begin
                if (cmd.valid && s.cmd_ready) begin
                    case (s.cidx)
                        tmd_pkg::TMD_TYPE_IDX: n.ctype = cmd.data;
                        tmd_pkg::TMD_BANK_IDX: n.cbank = cmd.data; // RULE8
                        tmd_pkg::TMD_PAGE_IDX: n.cpage = cmd.data; // RULE8
                        tmd_pkg::TMD_FLAGS_IDX: n.cflags = cmd.data; // RULE8
                        default: ;
                    endcase
                    if (s.cidx != tmd_pkg::TMD_CIDX_MAX) begin
                        n.cidx = s.cidx + 6'h01;
                    end
                    if (cmd.last) begin
                        n.cidx = 6'h00;
                        // Other packet types and short packets are dropped
                        if (s.ctype == tmd_pkg::TMD_CMD_TYPE
                            && s.cidx > tmd_pkg::TMD_FLAGS_IDX) begin
                            n.st = tmd_pkg::TMD_CHECK; // RULE1
                        end
                    end
                end
            end
            tmd_pkg::TMD_CHECK: begin
                n.ok = 1'b0;
                n.st = tmd_pkg::TMD_SEND;
                n.rcode = tmd_pkg::TMD_RC_FAILED;
                n.rreas = tmd_pkg::TMD_RS_NONE;
                if (!cfg.pluggable) begin
                    n.rcode = tmd_pkg::TMD_RC_UNSUP; // RULE7
                    n.rreas = tmd_pkg::TMD_RS_UNSUP; // RULE7
                end else if (!mod_stat.present) begin
                    n.rcode = tmd_pkg::TMD_RC_UNAVAIL; // RULE10
                    n.rreas = tmd_pkg::TMD_RS_NOINFO; // RULE10
                end else if (mod_stat.busy) begin
                    n.rreas = tmd_pkg::TMD_RS_NOINFO; // RULE12
                end else if (!mod_stat.powered) begin
                    n.rreas = tmd_pkg::TMD_RS_NOPOWER; // RULE13
                end else if (range_bad) begin
                    n.rreas = tmd_pkg::TMD_RS_RANGE; // RULE11
                end else if (cfg.cache_en && s.cache_valid && page0_upper) begin
                    n.dbuf = s.cache; // RULE5
                    n.ok = 1'b1;
                    n.rcode = tmd_pkg::TMD_RC_OK;
                end else begin
                    // Any page in range is read, mandatory or not
                    n.st = tmd_pkg::TMD_FETCH; // RULE6 RULE19
                    n.start = 1'b1;
                    n.idx = 8'h00;
                    n.fill = cfg.cache_en && page0_upper; // RULE5
                end
            end
            tmd_pkg::TMD_FETCH: begin
                if (eng_done) begin
                    if (eng_err) begin
                        n.st = tmd_pkg::TMD_SEND; // RULE19
                        n.rcode = tmd_pkg::TMD_RC_FAILED;
                        n.rreas = tmd_pkg::TMD_RS_NOINFO;
                    end else if (eng_tout) begin
                        n.st = tmd_pkg::TMD_SEND;
                        if (cfg.delayed) begin
                            n.rcode = tmd_pkg::TMD_RC_DELAYED; // RULE14
                            n.rreas = tmd_pkg::TMD_RS_NONE;
                        end else begin
                            n.rcode = tmd_pkg::TMD_RC_FAILED; // RULE14
                            n.rreas = tmd_pkg::TMD_RS_TIMEOUT;
                        end
                    end else begin
                        n.dbuf[s.idx[6:0]] = eng_data; // RULE1
                        if (s.idx[6:0] == tmd_pkg::TMD_BLK_LAST) begin
                            n.st = tmd_pkg::TMD_SEND; // RULE19
                            n.ok = 1'b1;
                            n.rcode = tmd_pkg::TMD_RC_OK;
                            n.rreas = tmd_pkg::TMD_RS_NONE;
                            if (s.fill) begin
                                n.cache = n.dbuf; // RULE5
                                n.cache_valid = 1'b1;
                            end
                        end else begin
                            n.idx = s.idx + 8'h01;
                            n.start = 1'b1;
                        end
                    end
                end
            end
            tmd_pkg::TMD_SEND: begin
                if (rsp_ready && s.rsp.valid) begin
                    if (s.rsp.last) begin
                        n.rsp.valid = 1'b0;
                        n.rsp.last = 1'b0;
                        n.st = tmd_pkg::TMD_IDLE;
                    end else begin
                        n.idx = s.idx + 8'h01;
                        n.rsp.data = tmd_rsp_byte(s, n.idx, cfg);
                        n.rsp.last = n.idx == (s.ok ?
                            tmd_pkg::TMD_RSP_LAST_OK :
                            tmd_pkg::TMD_RSP_LAST_ERR); // RULE15
                    end
                end
            end
            default: n.st = tmd_pkg::TMD_IDLE;
        endcase
        // First response byte is loaded on entry to the send state
        if (s.st != tmd_pkg::TMD_SEND && n.st == tmd_pkg::TMD_SEND) begin
            n.idx = 8'h00;
            n.rsp.valid = 1'b1;
            n.rsp.last = 1'b0;
            n.rsp.kind = tmd_pkg::TMD_RSP_TYPE; // RULE15
            n.rsp.data = tmd_rsp_byte(n, 8'h00, cfg);
            if (n.ok) begin
                n.served = s.served + 16'h0001;
            end else begin
                n.failed = s.failed + 16'h0001;
            end
        end
        n.cmd_ready = n.st == tmd_pkg::TMD_IDLE;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign cmd_ready = s.cmd_ready;
    assign rsp = s.rsp;
endmodule
`default_nettype wire
